// ### uwcs_pkg.sv
package uwcs_pkg;
    localparam logic [1:0] WM_OFF       = 2'h0;
    localparam logic [1:0] WM_THREE     = 2'h1;
    localparam logic [1:0] WM_TWO       = 2'h2;
    localparam logic [1:0] WM_TWO_OVF   = 2'h3;
    localparam int         CS_HI_BIT    = 1;
    localparam logic [1:0] CS_SOFT      = 2'h0;
    localparam logic [1:0] CS_TIMER     = 2'h1;
    localparam logic       CS_EDGE_NEG  = 1'h1;
    localparam logic [1:0] MODE_RST     = 2'h0;
    localparam logic [1:0] CS_RST       = 2'h0;
endpackage : uwcs_pkg

// ### uwcs_core.sv
`timescale 1ns/1ps
module uwcs_core (
    input  wire logic             i_core_clk,
    input  wire logic             i_nrst,
    input  wire logic             i_clk_en,
    input  wire logic [1:0]       i_wire_mode_select,
    input  wire logic [1:0]       i_clock_source_select,
    input  wire logic             i_clock_strobe,
    input  wire logic             i_clock_toggle_strobe,
    input  wire logic             i_timer_match,
    input  wire logic             i_shift_msb,
    input  wire logic             i_start_condition_flag,
    input  wire logic             i_counter_overflow_flag,
    input  wire logic             i_do_port,
    input  wire logic             i_do_ddr,
    input  wire logic             i_sda_port,
    input  wire logic             i_sda_ddr,
    input  wire logic             i_scl_port,
    input  wire logic             i_scl_ddr,
    input  wire logic             i_sda_pin,
    input  wire logic             i_serial_clock_pin,
    output logic                  o_do_out,
    output logic                  o_do_oe,
    output logic                  o_do_pullup,
    output logic                  o_sda_out,
    output logic                  o_sda_oe,
    output logic                  o_sda_pullup,
    output logic                  o_scl_out,
    output logic                  o_scl_oe,
    output logic                  o_scl_pullup,
    output logic                  o_scl_toggle,
    output logic                  o_start_det_en,
    output logic                  o_shift_clk,
    output logic                  o_sample_en,
    output logic                  o_sda_in,
    output logic                  o_serial_in_pin
);
    import uwcs_pkg::*;

    logic [1:0] mode_q;
    logic [1:0] cs_q;
    logic       sda_s1_q, sda_s2_q, sck_s1_q, sck_s2_q, sck_prev_q;
    logic       latch_q;
    logic       two_wire, three_wire, ext_src, sck_rise, sck_fall, hold;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_q <= MODE_RST;
            cs_q   <= CS_RST;
        end else if (i_clk_en) begin
            mode_q <= i_wire_mode_select;
            cs_q   <= i_clock_source_select;
        end
    end

    // Pins come from the far side, so both pass two flops before use.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sda_s1_q   <= 1'h1;
            sda_s2_q   <= 1'h1;
            sck_s1_q   <= 1'h0;
            sck_s2_q   <= 1'h0;
            sck_prev_q <= 1'h0;
        end else if (i_clk_en) begin
            sda_s1_q   <= i_sda_pin;
            sda_s2_q   <= sda_s1_q;
            sck_s1_q   <= i_serial_clock_pin;
            sck_s2_q   <= sck_s1_q;
            sck_prev_q <= sck_s2_q;
        end
    end

    assign two_wire   = mode_q[1];
    assign three_wire = (mode_q == WM_THREE);
    assign ext_src    = cs_q[CS_HI_BIT];
    assign sck_rise   = sck_s2_q & ~sck_prev_q;
    assign sck_fall   = ~sck_s2_q & sck_prev_q;

    assign hold = two_wire & (i_start_condition_flag |
                  ((mode_q == WM_TWO_OVF) & i_counter_overflow_flag));

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            latch_q <= 1'h1;
        end else if (i_clk_en) begin
            if (!ext_src || (cs_q[0] == CS_EDGE_NEG ? sck_rise : sck_fall)) begin
                latch_q <= i_shift_msb;
            end
        end
    end

    always_comb begin
        o_sample_en = 1'h0;
        if (ext_src) begin
            if (i_clock_strobe) begin
                o_sample_en = i_clock_toggle_strobe;
            end else begin
                o_sample_en = (cs_q[0] == CS_EDGE_NEG) ? sck_fall : sck_rise;
            end
        end else if (cs_q == CS_SOFT) begin
            o_sample_en = i_clock_strobe;
        end else begin
            o_sample_en = i_timer_match;
        end
    end
    assign o_shift_clk = o_sample_en;

    always_comb begin
        o_do_out     = i_do_port;
        o_do_oe      = i_do_ddr;
        o_do_pullup  = ~i_do_ddr & i_do_port;
        o_sda_out    = i_sda_port;
        o_sda_oe     = i_sda_ddr;
        o_sda_pullup = ~i_sda_ddr & i_sda_port;
        o_scl_out    = i_scl_port;
        o_scl_oe     = i_scl_ddr;
        o_scl_pullup = ~i_scl_ddr & i_scl_port;
        if (three_wire) begin
            o_do_out    = ext_src ? latch_q : i_shift_msb;
            o_do_pullup = ~i_do_ddr & i_do_port;
        end else if (two_wire) begin
            o_sda_out    = 1'h0;
            o_sda_oe     = i_sda_ddr & ~((ext_src ? latch_q : i_shift_msb) & i_sda_port);
            // Clock low on zero or hold.
            o_scl_out    = 1'h0;
            o_scl_oe     = i_scl_ddr & (~i_scl_port | hold);
            o_sda_pullup = 1'h0;
            o_scl_pullup = 1'h0;
        end
    end

    assign o_scl_toggle    = (mode_q != WM_OFF) & i_clock_toggle_strobe;
    assign o_start_det_en  = two_wire;
    assign o_sda_in        = sda_s2_q;
    assign o_serial_in_pin = sda_s2_q;

    // a_off_passthru: disabled mode follows port.
    a_off_passthru: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (mode_q == WM_OFF) |-> (o_sda_oe == i_sda_ddr && o_scl_out == i_scl_port))
        else $error("Disabled mode not passthrough.");
    a_three_override: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (three_wire && !ext_src) |-> (o_do_out == i_shift_msb && o_do_oe == i_do_ddr))
        else $error("Three-wire data override wrong.");
    a_three_pullup: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (three_wire && !i_do_ddr) |-> (o_do_pullup == i_do_port))
        else $error("Three-wire pull-up wrong.");
    a_three_clkpin: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        three_wire |-> (o_scl_oe == i_scl_ddr && o_sda_out == i_sda_port))
        else $error("Three-wire clock pin overridden.");
    a_toggle_strobe: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_clock_toggle_strobe && mode_q != WM_OFF) |-> o_scl_toggle)
        else $error("Toggle strobe lost.");
    a_two_opendrain: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        two_wire |-> (!o_sda_out && !o_scl_out && (i_sda_ddr || !o_sda_oe)))
        else $error("Two-wire driver not open-collector.");
    a_sda_pull_low: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (two_wire && i_sda_ddr && !i_sda_port) |-> o_sda_oe)
        else $error("Data line not pulled low.");
    a_scl_hold: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (two_wire && i_scl_ddr && i_start_condition_flag) |-> o_scl_oe)
        else $error("Clock not held after start.");
    a_scl_release: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (two_wire && i_scl_port && !hold) |-> !o_scl_oe)
        else $error("Clock not released.");
    a_two_pullups: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        two_wire |-> (!o_sda_pullup && !o_scl_pullup))
        else $error("Pull-ups active in two-wire mode.");
    a_ovf_hold: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (mode_q == WM_TWO_OVF && i_scl_ddr && i_counter_overflow_flag) |-> o_scl_oe)
        else $error("Clock not held after overflow.");
    a_soft_strobe: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (cs_q == CS_SOFT) |-> (o_shift_clk == i_clock_strobe))
        else $error("Software strobe not applied.");
    a_ext_toggle: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (ext_src && i_clock_strobe) |-> (o_shift_clk == i_clock_toggle_strobe))
        else $error("External toggle select wrong.");
    a_mode_delay: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_clk_en |=> (mode_q == $past(i_wire_mode_select)))
        else $error("Mode not taken next cycle.");
    a_latch_hold: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (ext_src && i_clk_en && !sck_rise && !sck_fall) |=> (latch_q == $past(latch_q)))
        else $error("Output latch moved without a clock edge.");
    a_latch_edge: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (ext_src && i_clk_en && ((cs_q[0] == CS_EDGE_NEG) ? sck_rise : sck_fall))
        |=> (latch_q == $past(i_shift_msb)))
        else $error("Output latch missed its edge.");
    a_sda_transp: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (two_wire && !ext_src && i_sda_ddr && i_sda_port) |-> (o_sda_oe == !i_shift_msb))
        else $error("Data line latch not transparent.");
endmodule : uwcs_core

// ### uwcs_peer.sv
`timescale 1ns/1ps
module uwcs_peer (
    output logic o_scl,
    output logic o_sda
);
    // Between frames the clock stands still low and the data line is released high.
    initial begin
        o_scl = 1'h0;
        o_sda = 1'h1;
    end
    // One frame of eight bits at a 48 ns period, high bit first.
    task automatic run_frame(input logic [7:0] data);
        for (int i = 7; i >= 0; i--) begin
            o_sda = data[i];
            #12 o_scl = 1'h1;
            #24 o_scl = 1'h0;
            #12;
        end
        o_sda = 1'h1;
    endtask : run_frame
endmodule : uwcs_peer

// ### usi_wire_mode_and_clock_select_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module usi_wire_mode_and_clock_select_tb;
    import uwcs_pkg::*;
    logic       clk, nrst, strobe, tog, tmr, msb, sflag, oflag, dop, dod, sdp, sdd, scp, scd;
    logic [1:0] mode, src;
    logic       p_scl, p_sda, sda_pin, scl_pin, do_out, do_oe, do_pu, sda_out, sda_oe, sda_pu;
    logic       scl_out, scl_oe, scl_pu, scl_tog, sdet, shclk, sda_in, cen, smp, sin;
    logic [7:0] rx;
    int         miscompares, n_checks, pulses, p0;
    uwcs_core uut (
        .i_core_clk(clk), .i_nrst(nrst), .i_clk_en(cen), .i_wire_mode_select(mode),
        .i_clock_source_select(src), .i_clock_strobe(strobe), .i_clock_toggle_strobe(tog),
        .i_timer_match(tmr), .i_shift_msb(msb), .i_start_condition_flag(sflag),
        .i_counter_overflow_flag(oflag), .i_do_port(dop), .i_do_ddr(dod), .i_sda_port(sdp),
        .i_sda_ddr(sdd), .i_scl_port(scp), .i_scl_ddr(scd), .i_sda_pin(sda_pin),
        .i_serial_clock_pin(scl_pin), .o_do_out(do_out), .o_do_oe(do_oe), .o_do_pullup(do_pu),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_sda_pullup(sda_pu), .o_scl_out(scl_out),
        .o_scl_oe(scl_oe), .o_scl_pullup(scl_pu), .o_scl_toggle(scl_tog),
        .o_start_det_en(sdet), .o_shift_clk(shclk), .o_sample_en(smp), .o_sda_in(sda_in),
        .o_serial_in_pin(sin)
    );
    uwcs_peer peer (.o_scl(p_scl), .o_sda(p_sda));
    // Wired line: a driven low wins over the released level of either party.
    assign sda_pin = (sda_oe ? sda_out : 1'h1) & p_sda;
    assign scl_pin = (scl_oe ? scl_out : 1'h1) & p_scl;
    // Count shift pulses and rebuild the received byte from the data input pin.
    always @(posedge clk) begin
        if (shclk === 1'h1) pulses <= pulses + 1;
        if (smp === 1'h1) rx <= {rx[6:0], sin};
    end
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    task automatic nx(input int n);
        repeat (n) @(negedge clk);
    endtask : nx
    task automatic fin(input string s);
        $display("test %s done", s);
    endtask : fin
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #20000;
        miscompares++;
        give_verdict();
    end
    initial begin
        // Port bits of the data output and data line start high, all strobes low.
        {strobe, tog, tmr, msb, sflag, oflag, dop, dod, sdp, sdd, scp, scd, nrst} = 13'h078;
        cen = 1'h1;
        mode = WM_OFF;
        src = CS_SOFT;
        repeat (16) @(posedge clk);
        nx(1);
        nrst = 1'h1;
        nx(1);
        mode = WM_THREE;
        #1 `CHK({do_out, do_oe, sdet}, 3'h6) // old mode
        nx(1);
        dod = 1'h0;
        tog = 1'h1;
        #1 `CHK({do_pu, scl_tog, sda_out, sda_oe}, 4'hf) // pins
        nx(1);
        dod = 1'h1;
        #1 `CHK({do_out, do_oe}, 2'h1) // serial out
        nx(1);
        dod = 1'h0;
        dop = 1'h0;
        tog = 1'h0;
        #1 `CHK(do_pu, 1'h0) // pull-up follows
        fin("three-wire");
        // A low clock enable must keep the old mode in force.
        cen = 1'h0;
        mode = WM_TWO;
        nx(2);
        #1 `CHK(sdet, 1'h0) // frozen mode
        cen = 1'h1;
        scd = 1'h1;
        scp = 1'h1;
        nx(2);
        #1 `CHK({scl_out, sda_out, sda_oe, sda_pu, scl_pu, scl_oe, sdet}, 7'h11)
        for (int i = 0; i < 4; i++) begin
            nx(1);
            msb = i[0];
            sdp = i[1];
            #1 `CHK(sda_oe, ~(msb & sdp)) // data pull
        end
        nx(1);
        sdp = 1'h0;
        nx(3);
        #1 `CHK(sda_in, 1'h0) // input path
        nx(1);
        scp = 1'h0;
        #1 `CHK(scl_oe, 1'h1) // clock pull
        nx(1);
        scp = 1'h1;
        sflag = 1'h1;
        #1 `CHK(scl_oe, 1'h1) // start hold
        nx(1);
        sflag = 1'h0;
        oflag = 1'h1;
        mode = WM_TWO_OVF;
        #1 `CHK(scl_oe, 1'h0) // hold release
        nx(1);
        #1 `CHK(scl_oe, 1'h1) // overflow hold
        nx(1);
        oflag = 1'h0;
        #1 `CHK(scl_oe, 1'h0) // overflow release
        fin("two-wire");
        mode = WM_THREE;
        scd = 1'h0;
        // The data pin is released so the peer alone drives it during frames.
        sdd = 1'h0;
        strobe = 1'h1;
        #1 `CHK(shclk, 1'h1) // soft strobe
        nx(1);
        strobe = 1'h0;
        tmr = 1'h1;
        src = CS_TIMER;
        #1 `CHK(shclk, 1'h0) // timer ignored
        nx(1);
        msb = 1'h0;
        strobe = 1'h1;
        #1 `CHK({shclk, do_out}, 2'h2) // timer clocks
        nx(1);
        tmr = 1'h0;
        src = 2'h2;
        nx(1);
        tog = 1'h1;
        #1 `CHK(shclk, 1'h1) // toggle clocking
        nx(1);
        tog = 1'h0;
        strobe = 1'h0;
        msb = 1'h1;
        nx(1);
        tog = 1'h1;
        #1 `CHK({shclk, do_out}, 2'h0) // latch holds
        nx(1);
        tog = 1'h0;
        p0 = pulses;
        peer.run_frame(8'ha5);
        nx(6);
        #1 `CHK({pulses - p0 == 8, do_out, rx}, 10'h3a5) // rising sample
        src = 2'h3;
        nx(2);
        p0 = pulses;
        peer.run_frame(8'h3c);
        nx(6);
        #1 `CHK({pulses - p0 == 8, rx}, 9'h13c) // falling sample
        fin("sources");
        give_verdict();
    end
endmodule : usi_wire_mode_and_clock_select_tb
